// ===== design/lsp_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsp_cfg.svh"
module lsp_sequencer #(
   parameter int NCH = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic syncGatePinIn,
   output logic syncGatePinOut,
   output logic syncGatePinOe,
   output logic [NCH-1:0] ledOn
);
   import lsp_pkg::*;

   function automatic logic [10:0] dwellLimit(input logic [3:0] code);
      dwellLimit = (code == 4'h0) ? 11'h1 : 11'(code * `LSP_DWELL_MULT);
   endfunction

   logic [2:0] enableQ;
   logic [2:0] modeQ;
   lsp_sync_e syncModeQ;
   logic [15:0] levelQ [NCH];
   logic [23:0] timeQ [NCH];
   logic [31:0] prdataQ;
   logic [3:0] dutyQ [NCH];
   lsp_state_e stateQ [NCH];

   // Bus decode
   wire setupPhase = psel & ~penable;
   wire accessPhase = psel & penable;
   wire [11:0] chOff = paddr - `LSP_ADDR_LEVEL0;
   wire [1:0] chSel = chOff[4:3];
   wire inChRange = (paddr >= `LSP_ADDR_LEVEL0) && (chOff < 12'(NCH * 8)) && (paddr[1:0] == 2'b00);
   wire isLevel = inChRange & ~chOff[2];
   wire isTime = inChRange & chOff[2];
   wire isCtrl = (paddr == `LSP_ADDR_CTRL);
   wire isStatus = (paddr == `LSP_ADDR_STATUS);
   wire mapped = isCtrl | isStatus | inChRange;
   wire wrStrobe = accessPhase & pwrite & mapped;

   assign pready = 1'b1;
   assign pslverr = accessPhase & (~mapped | (pwrite & isStatus));
   assign prdata = prdataQ;

   logic [31:0] statusWord;
   logic [31:0] readMux;
   always_comb
   begin
      statusWord = 32'h0;
      for (int c = 0; c < NCH; c++)
      begin
         statusWord[c*4 +: 4] = dutyQ[c];
         statusWord[16 + c] = (stateQ[c] != LSP_IDLE) && (stateQ[c] != LSP_DELAY);
      end
      readMux = 32'h0;
      if (isCtrl)
      begin
         readMux[`LSP_CTRL_EN_LSB +: 3] = enableQ;
         readMux[`LSP_CTRL_MODE_LSB +: 3] = modeQ;
         readMux[`LSP_CTRL_SYNC_LSB +: 2] = syncModeQ;
      end
      else if (isStatus)
         readMux = statusWord;
      else if (isLevel)
         readMux = {16'h0, levelQ[chSel]};
      else if (isTime)
         readMux = {8'h0, timeQ[chSel]};
   end

   // Read data caught in setup so the access phase needs no wait
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         prdataQ <= 32'h0;
      else if (setupPhase && !pwrite)
         prdataQ <= readMux;

   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         enableQ <= 3'h0;
         modeQ <= 3'h0;
         syncModeQ <= LSP_SYNC_OFF;
      end
      else if (wrStrobe && isCtrl)
      begin
         enableQ <= pwdata[`LSP_CTRL_EN_LSB +: 3];
         modeQ <= pwdata[`LSP_CTRL_MODE_LSB +: 3];
         syncModeQ <= lsp_sync_e'(pwdata[`LSP_CTRL_SYNC_LSB +: 2]);
      end

   // Sync pin: two flops before use, third only for edge detection
   logic [2:0] pinSyncQ;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         pinSyncQ <= 3'h0;
      else
         pinSyncQ <= {pinSyncQ[1:0], syncGatePinIn};
   wire pinLevel = pinSyncQ[1];
   wire pinRise = pinSyncQ[1] & ~pinSyncQ[2];

   // Reference tick, internal divider or external clock edges
   logic [7:0] divQ;
   logic clkOutQ;
   wire divEnd = (divQ == 8'(`LSP_REF_DIV - 1));
   wire refTick = (syncModeQ == LSP_SYNC_CLKIN) ? pinRise : divEnd;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         divQ <= 8'h0;
         clkOutQ <= 1'b0;
      end
      else
      begin
         divQ <= divEnd ? 8'h0 : divQ + 8'h1;
         clkOutQ <= (divQ < 8'(`LSP_REF_DIV / 2));
      end
   assign syncGatePinOe = (syncModeQ == LSP_SYNC_CLKOUT);
   assign syncGatePinOut = clkOutQ & syncGatePinOe;

   // PWM period of 128 reference ticks
   logic [6:0] pwmCntQ;
   wire periodEnd = refTick && (pwmCntQ == 7'(`LSP_PWM_TICKS - 1));
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         pwmCntQ <= 7'h0;
      else if (refTick)
         pwmCntQ <= pwmCntQ + 7'h1;

   // Gate passes unless external PWM mode holds the pin low
   wire gateOpen = (syncModeQ != LSP_SYNC_GATE) | pinLevel;

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : gCh
         logic [10:0] stepCntQ;
         logic [13:0] ttCntQ;
         logic ledQ;
         lsp_state_e stateD;
         logic [3:0] dutyD;
         logic [10:0] stepCntD;
         logic [13:0] ttCntD;

         always_ff @(posedge clk or negedge reset_n)
            if (!reset_n)
            begin
               levelQ[g] <= `LSP_LEVEL_RESET;
               timeQ[g] <= `LSP_TIME_RESET;
            end
            else if (wrStrobe && chSel == 2'(g))
            begin
               if (isLevel)
                  levelQ[g] <= pwdata[15:0];
               if (isTime)
                  timeQ[g] <= pwdata[23:0];
            end

         wire [3:0] lowV = levelQ[g][3:0];
         wire [3:0] midRaw = levelQ[g][7:4];
         wire [3:0] highRaw = levelQ[g][11:8];
         wire [3:0] delayCode = levelQ[g][15:12];
         wire [3:0] midV = (lowV >= midRaw) ? lowV : midRaw;
         wire [3:0] highV = (midV >= highRaw) ? midV : highRaw;
         wire [3:0] tt1 = timeQ[g][19:16];
         wire [3:0] tt2 = timeQ[g][23:20];
         wire [10:0] stepNext = stepCntQ + 11'h1;
         wire [13:0] ttNext = ttCntQ + 14'h1;
         wire [1:0] phIdx = (stateQ[g] == LSP_PH2) ? 2'h1 : (stateQ[g] == LSP_PH3) ? 2'h2 :
                            (stateQ[g] == LSP_PH4) ? 2'h3 : 2'h0;
         wire stepDone = stepNext >= dwellLimit(timeQ[g][phIdx*4 +: 4]);
         wire delayDone = stepNext >= 11'(delayCode * `LSP_DWELL_MULT);
         wire riseOver = (tt1 != 4'h0) && (ttNext >= 14'(tt1 * `LSP_TT_MULT));
         wire fallOver = (tt2 != 4'h0) && (ttNext >= 14'(tt2 * `LSP_TT_MULT));

         always_comb
         begin
            stateD = stateQ[g];
            dutyD = dutyQ[g];
            stepCntD = stepCntQ;
            ttCntD = ttCntQ;
            if (!enableQ[g])
            begin
               stateD = LSP_IDLE;
               stepCntD = 11'h0;
               ttCntD = 14'h0;
            end
            else if (periodEnd)
            begin
               stepCntD = stepDone ? 11'h0 : stepNext;
               ttCntD = ttNext;
               case (stateQ[g])
                  LSP_IDLE:
                  begin
                     stateD = LSP_DELAY;
                     stepCntD = 11'h0;
                  end
                  LSP_DELAY:
                  begin
                     stepCntD = stepNext;
                     if (delayCode == 4'h0 || delayDone)
                     begin
                        stateD = modeQ[g] ? LSP_PH1 : LSP_CONST;
                        dutyD = modeQ[g] ? lowV : 4'hf;
                        stepCntD = 11'h0;
                        ttCntD = 14'h0;
                     end
                  end
                  LSP_CONST:
                     stepCntD = 11'h0;
                  LSP_PH1, LSP_PH2:
                     if (riseOver)
                     begin
                        stateD = LSP_PH3;
                        dutyD = highV;
                        stepCntD = 11'h0;
                        ttCntD = 14'h0;
                     end
                     else if (stepDone)
                     begin
                        if (stateQ[g] == LSP_PH1)
                        begin
                           if (dutyQ[g] < midV)
                              dutyD = dutyQ[g] + 4'h1;
                           else
                              stateD = LSP_PH2;
                        end
                        else if (dutyQ[g] < highV)
                           dutyD = dutyQ[g] + 4'h1;
                        else
                        begin
                           stateD = LSP_PH3;
                           ttCntD = 14'h0;
                        end
                     end
                  LSP_PH3, LSP_PH4:
                     if (fallOver)
                     begin
                        stateD = LSP_PH1;
                        dutyD = lowV;
                        stepCntD = 11'h0;
                        ttCntD = 14'h0;
                     end
                     else if (stepDone)
                     begin
                        if (stateQ[g] == LSP_PH3)
                        begin
                           if (dutyQ[g] > midV)
                              dutyD = dutyQ[g] - 4'h1;
                           else
                              stateD = LSP_PH4;
                        end
                        else if (dutyQ[g] > lowV)
                           dutyD = dutyQ[g] - 4'h1;
                        else
                        begin
                           stateD = LSP_PH1;
                           ttCntD = 14'h0;
                        end
                     end
                  default:
                     stateD = LSP_IDLE;
               endcase
            end
         end

         always_ff @(posedge clk or negedge reset_n)
            if (!reset_n)
            begin
               stateQ[g] <= LSP_IDLE;
               dutyQ[g] <= 4'h0;
               stepCntQ <= 11'h0;
               ttCntQ <= 14'h0;
            end
            else
            begin
               stateQ[g] <= stateD;
               dutyQ[g] <= dutyD;
               stepCntQ <= stepCntD;
               ttCntQ <= ttCntD;
            end

         // Constant mode is full on; slope duty sets on-slots of 8 ticks out of 16
         wire slopeOn = (pwmCntQ[6:3] < dutyQ[g]);
         wire runOn = (stateQ[g] == LSP_CONST) |
                      (((stateQ[g] & (LSP_PH1 | LSP_PH2 | LSP_PH3 | LSP_PH4)) != 7'h0) & slopeOn);
         always_ff @(posedge clk or negedge reset_n)
            if (!reset_n)
               ledQ <= 1'b0;
            else
               ledQ <= runOn & gateOpen & enableQ[g];
         assign ledOn[g] = ledQ;
      end
   endgenerate
endmodule
`default_nettype wire

// ===== design/lsp_cfg.svh
// How it works
// - Mode bit 0 gives constant current
// - Mode bit 1 gives slope sequence
// - Constant output starts after start delay
// - Slope runs phases 1-4 repeatedly after delay
// - Sequencing paced by 2.40 MHz reference tick, or by sync pin edges in clock input mode
// - Rising total time limits phases 1 and 2
// - Rising expiry jumps to phase 3 at high
// - Falling total time limits phases 3 and 4
// - Falling expiry jumps to phase 1 at low
// - Phase 1 steps low up to middle
// - Phase 2 steps middle up to high
// - Phase 3 steps high down to middle
// - Phase 4 steps middle down to low
// - External PWM mode gates output by pin
// - Sync pin unused, clock input or output
// - Dwell code 0 one period, else 75n
// - Per channel high, middle, low, delay fields
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH
`define LSP_CLK_HZ 125000000
`define LSP_REF_HZ 2400000
`define LSP_REF_DIV (`LSP_CLK_HZ / `LSP_REF_HZ)
`define LSP_PWM_TICKS 128
`define LSP_DWELL_MULT 75
`define LSP_TT_MULT 600
`define LSP_ADDR_CTRL 12'h000
`define LSP_ADDR_STATUS 12'h004
`define LSP_ADDR_LEVEL0 12'h010
`define LSP_ADDR_TIME0 12'h014
`define LSP_CH_STRIDE 12'h008
`define LSP_CTRL_EN_LSB 0
`define LSP_CTRL_MODE_LSB 4
`define LSP_CTRL_SYNC_LSB 8
`define LSP_LEVEL_RESET 16'h0f80
`define LSP_TIME_RESET 24'h008888
`endif

// ===== design/lsp_pkg.sv
package lsp_pkg;
   typedef enum logic [6:0] {
      LSP_IDLE  = 7'b0000001,
      LSP_DELAY = 7'b0000010,
      LSP_CONST = 7'b0000100,
      LSP_PH1   = 7'b0001000,
      LSP_PH2   = 7'b0010000,
      LSP_PH3   = 7'b0100000,
      LSP_PH4   = 7'b1000000
   } lsp_state_e;
   typedef enum logic [1:0] {
      LSP_SYNC_OFF = 2'h0,
      LSP_SYNC_GATE = 2'h1,
      LSP_SYNC_CLKIN = 2'h2,
      LSP_SYNC_CLKOUT = 2'h3
   } lsp_sync_e;
endpackage

// ===== verification/lsp_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module lsp_seq_props #(
   parameter int NCH = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic syncGatePinIn,
   input wire logic syncGatePinOut,
   input wire logic syncGatePinOe,
   input wire logic [NCH-1:0] ledOn
);
   logic [9:0] ctrl_q;
   logic [9:0] ctrl_d;
   logic wrCtrl;
   logic mapped;
   assign wrCtrl = psel && penable && pwrite && paddr == 12'h000;
   assign mapped = paddr inside {12'h000, 12'h004, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024};
   assign ctrl_d = wrCtrl ? pwdata[9:0] : ctrl_q;
   // Shadow of the control word, since the checker cannot see inside
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         ctrl_q <= 10'h000;
      else
         ctrl_q <= ctrl_d;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Five samples cover the two-flop synchroniser plus output register
   sequence gateLowRun;
      (ctrl_q[9:8] == 2'h1 && !syncGatePinIn) [*5];
   endsequence
   sequence constLit;
      (ctrl_q[0] && !ctrl_q[4] && ctrl_q[9:8] != 2'h1) [*2] ##0 ledOn[0];
   endsequence
   pready_one_a: assert property (pready)
      else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   err_unmap_a: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   err_status_a: assert property (psel && penable && pwrite && paddr == 12'h004 |-> pslverr)
      else $error("status write not refused");
   oe_decode_a: assert property (wrCtrl |=> syncGatePinOe == (ctrl_q[9:8] == 2'h3))
      else $error("pin enable wrong");
   pin_quiet_a: assert property (!syncGatePinOe [*2] |-> !syncGatePinOut)
      else $error("pin drive without enable");
   clk_live_a: assert property (syncGatePinOe [*2] |-> ##[0:60] ($changed(syncGatePinOut) || !syncGatePinOe))
      else $error("clock output stuck");
   gate_low_a: assert property (gateLowRun |-> ledOn == '0)
      else $error("channel_enable_bit while gate low");
   dark_idle_a: assert property ((ctrl_q[NCH-1:0] == '0) [*4] |-> ledOn == '0)
      else $error("channel_enable_bit while disabled");
   const_hold_a: assert property (constLit |=> ledOn[0])
      else $error("constant output dropped");
endmodule
bind lsp_sequencer lsp_seq_props #(.NCH(NCH)) props_u (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .syncGatePinIn(syncGatePinIn),
   .syncGatePinOut(syncGatePinOut), .syncGatePinOe(syncGatePinOe), .ledOn(ledOn)
);
`default_nettype wire

// ===== verification/lsp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsp_pin_model (
   input wire logic clk,
   input wire logic runClk,
   input wire logic gateLvl,
   output logic pinDrv
);
   int cnt = 0;
   logic clkLvl = 1'b0;
   // Half period of 25 cycles, deliberately off the internal divider
   always @(posedge clk)
   begin
      cnt <= (cnt == 24) ? 0 : cnt + 1;
      if (runClk && cnt == 24)
         clkLvl <= !clkLvl;
   end
   assign pinDrv = runClk ? clkLvl : gateLvl;
endmodule
`default_nettype wire

// ===== verification/lsp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lsp_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pinOut;
   logic pinOe;
   logic srcLvl;
   logic runClk = 1'b0;
   logic gateLvl = 1'b0;
   logic [2:0] ledOn;
   logic pinLvl;
   logic [31:0] rd;
   logic er;
   int n_fail = 0;
   int num_checks = 0;
   assign pinLvl = pinOe ? pinOut : srcLvl;
   lsp_sequencer #(.NCH(3)) dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .syncGatePinIn(pinLvl), .syncGatePinOut(pinOut), .syncGatePinOe(pinOe), .ledOn(ledOn));
   lsp_pin_model src_u (.clk(clk), .runClk(runClk), .gateLvl(gateLvl), .pinDrv(srcLvl));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, 12'h010 + 12'(8 * i), 32'h0);
         chk("level reset", 32'h0f80, rd);
         apb(1'b0, 12'h014 + 12'(8 * i), 32'h0);
         chk("time reset", 32'h008888, rd);
      end
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      apb(1'b1, 12'h004, 32'hffff);
      chk("status write err", 32'h1, {31'h0, er});
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", 32'h0, rd);
   endtask
   task automatic t_const;
      int k;
      runClk <= 1'b1;
      apb(1'b1, 12'h000, {22'h0, LSP_SYNC_CLKIN, 8'h01});
      chk("clock in oe", 32'h0, {31'h0, pinOe});
      for (k = 0; k < 14000 && ledOn[0] !== 1'b1; k++) @(posedge clk);
      chk("const on", 32'h1, {31'h0, ledOn[0]});
      repeat (200) @(posedge clk);
      chk("const steady", 32'h1, {31'h0, ledOn[0]});
      runClk <= 1'b0;
      gateLvl <= 1'b1;
      apb(1'b1, 12'h000, {22'h0, LSP_SYNC_GATE, 8'h01});
      // Gate held 25.6 us per level, slow enough for the pin limit
      gateLvl <= 1'b0;
      repeat (3200) @(posedge clk);
      chk("gate low", 32'h0, {31'h0, ledOn[0]});
      gateLvl <= 1'b1;
      repeat (3200) @(posedge clk);
      chk("gate high", 32'h1, {31'h0, ledOn[0]});
      apb(1'b1, 12'h000, 32'h0);
      repeat (3) @(posedge clk);
      chk("disable", 32'h0, {29'h0, ledOn});
   endtask
   task automatic t_slope;
      logic [3:0] d;
      logic [3:0] dMin;
      logic [3:0] dMax;
      logic hi;
      logic back;
      logic mid;
      logic seenOn;
      logic seenOff;
      dMin = 4'hf;
      dMax = 4'h0;
      hi = 1'b0;
      back = 1'b0;
      mid = 1'b0;
      seenOn = 1'b0;
      seenOff = 1'b0;
      apb(1'b1, 12'h018, 32'h0543);
      apb(1'b1, 12'h01c, 32'h0);
      apb(1'b1, 12'h000, 32'h022);
      repeat (240)
      begin
         repeat (250) @(posedge clk);
         apb(1'b0, 12'h004, 32'h0);
         d = rd[7:4];
         if (rd[17] === 1'b1)
         begin
            dMin = (d < dMin) ? d : dMin;
            dMax = (d > dMax) ? d : dMax;
            hi = hi | (d == 4'h5);
            back = back | (hi && d == 4'h3);
            // Falling through middle after the peak
            mid = mid | (hi && d == 4'h4);
            seenOn = seenOn | (ledOn[1] === 1'b1);
            seenOff = seenOff | (ledOn[1] === 1'b0);
         end
      end
      chk("slope low", 32'h3, {28'h0, dMin});
      chk("slope high", 32'h5, {28'h0, dMax});
      chk("slope fall mid", 32'h1, {31'h0, mid});
      chk("slope fall low", 32'h1, {31'h0, back});
      chk("slope pwm", 32'h3, {30'h0, seenOn, seenOff});
      chk("slope return", 32'h1, {31'h0, back});
      apb(1'b1, 12'h000, 32'h0);
   endtask
   task automatic t_sync;
      logic p;
      int k;
      apb(1'b1, 12'h000, {22'h0, LSP_SYNC_CLKOUT, 8'h00});
      chk("out oe", 32'h1, {31'h0, pinOe});
      p = pinLvl;
      for (k = 0; k < 80 && pinLvl === p; k++) @(posedge clk);
      chk("clock out", {31'h0, ~p}, {31'h0, pinLvl});
      apb(1'b1, 12'h000, 32'h0);
      chk("unused oe", 32'h0, {31'h0, pinOe});
   endtask
   task automatic final_report;
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #800000;
      n_fail++;
      final_report();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_const();
      t_slope();
      t_sync();
      final_report();
   end
endmodule
`default_nettype wire
